/* File: periodic_tick_timer.sv */
// tick timer: mode register, count register and interrupt
// Operation
// - nonzero mode increments count every cycle while not stopped, except on a match in modes 01 and 10
// - match when count[27:0] equals period
// - mode 00 disables counting and interrupt
// - mode 01 clears count on match
// - mode 10 stops on match until count written
// - mode 11 counts through a match
// - interrupt on match only when enable set
// - enable clear means no interrupt
// - pending in bit 28, write zero clears
// - mode 31:30, ie 29, ip 28, period 27:0
// - supervisor reads and writes both registers
// - user reads count only when access enabled
// - count is full 32 bits
// - present register bit 10 reads one
`include "tick_timer_consts.svh"
module periodic_tick_timer #(
	parameter int PERIOD_W = 28
) (
	// clock and reset
	input  wire logic                     clock,
	input  wire logic                     sys_rst,
	// special-purpose register port
	input  wire tick_timer_pkg::spr_req_s spr_req,
	output tick_timer_pkg::spr_rsp_s      spr_rsp,
	// supervision register bit
	input  wire logic                     user_read_access_enable,
	// exception logic
	output logic                          tick_irq
);
	// the mode register packs exactly 28 period bits under its four control bits
	if (PERIOD_W != 28)
	begin
		$error("period field must be 28 bits");
	end

	tick_timer_pkg::tick_mode_e mode_r;
	logic                       tick_irq_enable_r;
	logic                       tick_irq_pending_r;
	logic [PERIOD_W-1:0]        compare_period_r;
	logic [31:0]                count_field_r;
	logic                       stopped_r;
	logic                       hit;
	logic                       allowed;
	logic                       wr_mode;
	logic                       wr_count;
	logic                       running;
	logic                       match_ev;
	logic [31:0]                rd_nxt;

	tick_match #(.PERIOD_W(PERIOD_W)) u_match (
		.count_value (count_field_r),
		.period      (compare_period_r),
		.hit         (hit)
	);

	tick_access u_access (
		.req                     (spr_req),
		.user_read_access_enable (user_read_access_enable),
		.allowed                 (allowed)
	);

	assign wr_mode  = spr_req.valid && spr_req.write && allowed && spr_req.sel == `TT_SPR_MODE;
	assign wr_count = spr_req.valid && spr_req.write && allowed && spr_req.sel == `TT_SPR_COUNT;
	assign running  = (mode_r != tick_timer_pkg::MODE_OFF) && !stopped_r;
	// a stopped timer keeps matching; the event counts only while active
	assign match_ev = hit && mode_r != tick_timer_pkg::MODE_OFF && !stopped_r;

	// mode register fields
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			mode_r            <= tick_timer_pkg::MODE_OFF;
			tick_irq_enable_r <= 1'b0;
			compare_period_r  <= `TT_PERIOD_RESET;
		end
		else if (wr_mode)
		begin
			mode_r            <= tick_timer_pkg::tick_mode_e'(spr_req.wdata[`TT_MODE_HI:`TT_MODE_LO]);
			tick_irq_enable_r <= spr_req.wdata[`TT_IE_BIT];
			compare_period_r  <= spr_req.wdata[PERIOD_W-1:0];
		end
	end

	// pending flag: a new match wins over a clearing write
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			tick_irq_pending_r <= 1'b0;
		else if (match_ev && tick_irq_enable_r)
			tick_irq_pending_r <= 1'b1;
		else if (wr_mode && !spr_req.wdata[`TT_IP_BIT])
			tick_irq_pending_r <= 1'b0;
	end

	// count register
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			count_field_r <= `TT_COUNT_RESET;
		else if (wr_count)
			count_field_r <= spr_req.wdata;
		else if (running && match_ev && mode_r == tick_timer_pkg::MODE_RESTART)
			count_field_r <= `TT_COUNT_RESET;
		else if (running && !(match_ev && mode_r == tick_timer_pkg::MODE_SINGLE))
			count_field_r <= count_field_r + 32'h0000_0001;
	end

	// single-run stop latch, released only by a count write
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			stopped_r <= 1'b0;
		else if (wr_count)
			stopped_r <= 1'b0;
		else if (match_ev && mode_r == tick_timer_pkg::MODE_SINGLE)
			stopped_r <= 1'b1;
	end

	assign tick_irq = tick_irq_pending_r && tick_irq_enable_r;

	always_comb
	begin
		rd_nxt = 32'h0000_0000;
		unique case (spr_req.sel)
			`TT_SPR_MODE:
				rd_nxt = {mode_r, tick_irq_enable_r, tick_irq_pending_r, compare_period_r};
			`TT_SPR_COUNT:
				rd_nxt = count_field_r;
			`TT_SPR_PRESENT:
				rd_nxt[`TT_PRESENT_BIT] = 1'b1;
			default:
				rd_nxt = 32'h0000_0000;
		endcase
	end

	// response registered one cycle after the request
	always_ff @(posedge clock or posedge sys_rst)
	begin
		if (sys_rst)
			spr_rsp <= '0;
		else
		begin
			spr_rsp.ack    <= spr_req.valid;
			spr_rsp.denied <= spr_req.valid && !allowed;
			spr_rsp.rdata  <= (spr_req.valid && !spr_req.write && allowed) ? rd_nxt : 32'h0000_0000;
		end
	end
endmodule

/* File: tick_timer_consts.svh */
// offsets, field positions, reset values and codes for the tick timer
`ifndef TICK_TIMER_CONSTS_SVH
`define TICK_TIMER_CONSTS_SVH
`define TT_SPR_MODE          2'h0
`define TT_SPR_COUNT         2'h1
`define TT_SPR_PRESENT       2'h2
`define TT_MODE_HI           31
`define TT_MODE_LO           30
`define TT_IE_BIT            29
`define TT_IP_BIT            28
`define TT_PERIOD_HI         27
`define TT_PRESENT_BIT       10
`define TT_COUNT_RESET       32'h0000_0000
`define TT_PERIOD_RESET      28'h000_0000
`endif

/* File: tick_timer_pkg.sv */
// types shared by the tick timer files
package tick_timer_pkg;
	typedef enum logic [1:0] {
		MODE_OFF     = 2'h0,
		MODE_RESTART = 2'h1,
		MODE_SINGLE  = 2'h2,
		MODE_FREE    = 2'h3
	} tick_mode_e;

	typedef struct packed {
		logic        valid;
		logic        write;
		logic        user_mode;
		logic [1:0]  sel;
		logic [31:0] wdata;
	} spr_req_s;

	typedef struct packed {
		logic        ack;
		logic        denied;
		logic [31:0] rdata;
	} spr_rsp_s;
endpackage

/* File: tick_match.sv */
// compares the low bits of the count with the period
`include "tick_timer_consts.svh"
module tick_match #(
	parameter int PERIOD_W = 28
) (
	// operands
	input  wire logic [31:0]         count_value,
	input  wire logic [PERIOD_W-1:0] period,
	// result
	output logic                     hit
);
	if (PERIOD_W < 1 || PERIOD_W > 32)
	begin
		$error("period width out of range");
	end

	assign hit = (count_value[PERIOD_W-1:0] == period);
endmodule

/* File: tick_access.sv */
// privilege check for register moves
`include "tick_timer_consts.svh"
module tick_access (
	// request
	input  wire tick_timer_pkg::spr_req_s req,
	input  wire logic                     user_read_access_enable,
	// decision
	output logic                          allowed
);
	always_comb
	begin
		if (!req.user_mode)
			allowed = 1'b1;
		else
			allowed = !req.write && req.sel == `TT_SPR_COUNT && user_read_access_enable;
	end
endmodule

/* File: tick_timer_props.sv */
// port checker for the tick timer
module tick_timer_props #(
	parameter int PERIOD_W = 28
) (
	// clock and reset
	input wire logic                     clock,
	input wire logic                     sys_rst,
	// register port and interrupt
	input wire tick_timer_pkg::spr_req_s spr_req,
	input wire tick_timer_pkg::spr_rsp_s spr_rsp,
	input wire logic                     user_read_access_enable,
	input wire logic                     tick_irq
);
	timeunit 1ns;
	timeprecision 1ns;
	wire logic v = spr_req.valid;
	wire logic w = spr_req.write;
	wire logic u = spr_req.user_mode;
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);
	property p_ack; v |=> spr_rsp.ack; endproperty
	a_ack: assert property (p_ack) else $error("missing ack");
	property p_idle; !v |=> !spr_rsp.ack; endproperty
	a_idle: assert property (p_idle) else $error("stray ack");
	property p_uw; v && w && u |=> spr_rsp.denied; endproperty
	a_uw: assert property (p_uw) else $error("user write allowed");
	property p_sv; v && !u |=> !spr_rsp.denied; endproperty
	a_sv: assert property (p_sv) else $error("supervisor refused");
	property p_ur; v && !w && spr_req.sel == 2'h1 && user_read_access_enable |=> !spr_rsp.denied; endproperty
	a_ur: assert property (p_ur) else $error("user count read refused");
	property p_us; v && u && spr_req.sel != 2'h1 |=> spr_rsp.denied; endproperty
	a_us: assert property (p_us) else $error("user mode read allowed");
	property p_dz; spr_rsp.denied |-> spr_rsp.ack && spr_rsp.rdata == 32'h0; endproperty
	a_dz: assert property (p_dz) else $error("refusal carries data");
	property p_pr; v && !w && !u && spr_req.sel == 2'h2 |=> spr_rsp.rdata == 32'h0000_0400; endproperty
	a_pr: assert property (p_pr) else $error("present bit wrong");
	property p_wz; v && w |=> spr_rsp.rdata == 32'h0; endproperty
	a_wz: assert property (p_wz) else $error("write returns data");
	property p_ie; v && w && !u && spr_req.sel == 2'h0 && !spr_req.wdata[29] |=> !tick_irq; endproperty
	a_ie: assert property (p_ie) else $error("interrupt with enable clear");
endmodule
bind periodic_tick_timer tick_timer_props #(.PERIOD_W(PERIOD_W)) chk (.clock(clock), .sys_rst(sys_rst),
	.spr_req(spr_req), .spr_rsp(spr_rsp), .user_read_access_enable(user_read_access_enable), .tick_irq(tick_irq));

/* File: spr_host.sv */
// processor side model issuing register moves
module spr_host (
	// clock and answer
	input wire logic                     clock,
	input wire tick_timer_pkg::spr_rsp_s rsp,
	// request
	output tick_timer_pkg::spr_req_s     req
);
	timeunit 1ns;
	timeprecision 1ns;
	initial req = '0;
	// one access per call; released fields invert so stale data never passes
	task automatic acc(input logic wr, us, input logic [1:0] s, input logic [31:0] d, output tick_timer_pkg::spr_rsp_s r);
		@(negedge clock);
		req <= {1'b1, wr, us, s, d};
		@(negedge clock);
		r = rsp;
		req <= {1'b0, ~req[35:0]};
	endtask
endmodule

/* File: periodic_tick_timer_tb.sv */
// testbench for the periodic tick timer
module periodic_tick_timer_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 0;
	logic sys_rst = 1;
	logic ura = 0;
	logic tick_irq;
	int bad_count, cmp_count, cyc;
	tick_timer_pkg::spr_req_s req;
	tick_timer_pkg::spr_rsp_s rsp, r;
	always #50 clock = ~clock;
	periodic_tick_timer DUT (.clock(clock), .sys_rst(sys_rst), .spr_req(req), .spr_rsp(rsp),
		.user_read_access_enable(ura), .tick_irq(tick_irq));
	spr_host host (.clock(clock), .rsp(rsp), .req(req));
	task automatic chk(input string n, input logic [31:0] s, e);
		cmp_count++;
		if (s !== e)
		begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic rd(input logic u, input logic [1:0] s);
		host.acc(0, u, s, 0, r);
		chk("read ack", r.ack, 1);
	endtask
	task automatic wr(input logic [1:0] s, input logic [31:0] d);
		host.acc(1, 0, s, d, r);
		chk("write ack", r.ack, 1);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// tests take about 110 cycles; a hang stops at 1000
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 1000)
		begin
			bad_count++;
			wrap_up;
		end
	end
	initial
	begin
		repeat (5) @(negedge clock);
		sys_rst = 0;
		rd(0, 0);
		chk("mode", r.rdata, 0);
		rd(0, 1);
		chk("count", r.rdata, 0);
		rd(0, 2);
		chk("present", r.rdata, 32'h0000_0400);
		rd(0, 3);
		chk("unmapped", r.rdata, 0);
		chk("irq reset", tick_irq, 0);
		$display("reset test done");
		// single run: holds on the period until the count is written
		wr(0, 32'hA000_0004);
		wr(1, 32'h0000_0000);
		repeat (10) @(negedge clock);
		rd(0, 1);
		chk("stop", r.rdata, 32'h0000_0004);
		rd(0, 0);
		chk("pend", r.rdata, 32'hB000_0004);
		chk("irq", tick_irq, 1);
		wr(0, 32'hA000_0004);
		chk("clear", tick_irq, 0);
		wr(0, 32'h0000_0000);
		wr(1, 32'h0000_0010);
		repeat (5) @(negedge clock);
		rd(0, 1);
		chk("off", r.rdata, 32'h0000_0010);
		// free run: written at one edge, one step per edge after, through the match
		wr(0, 32'hE000_0002);
		wr(1, 32'h0000_0000);
		repeat (10) @(negedge clock);
		rd(0, 1);
		chk("free", r.rdata, 32'h0000_000B);
		chk("irq on", tick_irq, 1);
		// a match while the enable is clear must leave pending low
		wr(0, 32'hC000_0002);
		wr(1, 32'h0000_0000);
		repeat (10) @(negedge clock);
		rd(0, 0);
		chk("masked", r.rdata, 32'hC000_0002);
		chk("irq off", tick_irq, 0);
		wr(0, 32'h4000_0003);
		wr(1, 32'h0000_0000);
		repeat (6) @(negedge clock);
		rd(0, 1);
		chk("restart", r.rdata, 32'h0000_0003);
		$display("mode test done");
		wr(0, 32'h8000_0000);
		wr(1, 32'h1000_0000);
		repeat (3) @(negedge clock);
		rd(0, 1);
		chk("low bits", r.rdata, 32'h1000_0000);
		rd(1, 1);
		chk("user off", r.denied, 1);
		host.acc(1, 1, 1, 0, r);
		chk("user wr", r.denied, 1);
		ura = 1;
		rd(1, 1);
		chk("user rd", r.rdata, 32'h1000_0000);
		rd(1, 0);
		chk("user mode", r.denied, 1);
		$display("access test done");
		// a reset while the single run is stopped on its match returns both registers to zero
		sys_rst = 1;
		@(negedge clock);
		sys_rst = 0;
		rd(0, 0);
		chk("mode again", r.rdata, 0);
		rd(0, 1);
		chk("count again", r.rdata, 0);
		$display("second reset test done");
		wrap_up;
	end
endmodule
